// file: common/pwmg_pkg.sv
// Package for the period/duty pulse-width generator
package pwmg_pkg;
	localparam int         PWMG_TMR_W       = 8;
	localparam int         PWMG_DUTY_W      = 10;
	localparam int         PWMG_PHASE_W     = 2;
	localparam int         PWMG_PS_W        = 4;
	// One timer increment per four oscillator periods, times the prescale
	localparam int         PWMG_QCLK_DIV    = 4;
	localparam logic [3:0] PWMG_MODE_PWM    = 4'hc;
	localparam logic [3:0] PWMG_MODE_MASK   = 4'hc;
	localparam int         PWMG_CTRL_LSB_HI = 5;
	localparam int         PWMG_CTRL_LSB_LO = 4;
	localparam int         PWMG_CTRL_MODE_HI = 3;
	localparam logic [7:0] PWMG_CTRL_RST    = 8'h00;
	localparam logic [7:0] PWMG_TMR_RST     = 8'h00;
	localparam logic [7:0] PWMG_LIMIT_RST   = 8'hff;

	// Software-side writes carried as one bundle
	typedef struct packed {
		logic       ctrl_we;
		logic [7:0] ctrl;
		logic       duty_we;
		logic [7:0] duty;
		logic       limit_we;
		logic [7:0] limit;
		logic [1:0] prescale_sel;
	} pwmg_cfg_t;

	function automatic logic pwmg_is_pwm(input logic [7:0] ctrl);
		return (ctrl[3:0] & PWMG_MODE_MASK) == PWMG_MODE_PWM;
	endfunction : pwmg_is_pwm
endpackage : pwmg_pkg

// file: tb/pwmg_tb.sv
// Self-checking bench for the pulse-width generator core
`timescale 1ns/10ps
module testbench;
	import pwmg_pkg::*;
	logic      i_mclk;
	logic      i_rstn;
	pwmg_cfg_t cfg;
	logic [7:0] shadow;
	logic [7:0] timer;
	logic       pin;
	int err_total, n_tests, seed, hi, tmax, lim, duty, ps, per, pd, model_sh;
	// Written duty upper bytes waiting for the next period start
	int pend_q[$];

	pwmg_core dut_u (
		.i_mclk              (i_mclk),
		.i_rstn              (i_rstn),
		.i_cfg               (cfg),
		.o_duty_value_shadow (shadow),
		.o_period_timer      (timer),
		.o_pwm_output_pin    (pin)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask : chk

	// Rule model: high clocks per period, clipped at the full period
	function automatic int exp_high(input int d, input int l, input int p);
		return ((d < (l + 1) * PWMG_QCLK_DIV) ? d : (l + 1) * PWMG_QCLK_DIV) * p;
	endfunction : exp_high

	// Rule model: a period start moves every pending duty into the shadow
	task automatic model_match;
		while (pend_q.size() > 0)
			model_sh = pend_q.pop_front();
	endtask : model_match

	task automatic wr(input logic [2:0] we, input logic [7:0] c, d, l, input logic [1:0] p);
		@(posedge i_mclk);
		cfg <= '{we[2], c, we[1], d, we[0], l, p};
		@(posedge i_mclk);
		cfg.ctrl_we  <= 1'b0;
		cfg.duty_we  <= 1'b0;
		cfg.limit_we <= 1'b0;
	endtask : wr

	// Any window of one whole period sees the full high time
	task automatic meas(input int n);
		hi = 0;
		tmax = 0;
		repeat (n) begin
			@(posedge i_mclk);
			#1;
			hi += (pin === 1'b1);
			if (timer > tmax) tmax = timer;
		end
	endtask : meas

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	initial begin
		#200000;
		err_total++;
		test_done();
	end

	initial begin
		seed = 32'h9ccb3d6a;
		err_total = 0;
		n_tests = 0;
		model_sh = 0;
		i_rstn = 1'b0;
		cfg = '0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		#1;
		chk({pin, timer, shadow}, 0, "reset");
		// Limits rise so the timer is never left above a new limit
		for (int i = 0; i < 8; i++) begin
			ps = i % 4;
			per = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
			lim = 2 + 3 * i + ($unsigned($random(seed)) % 2);
			pd = (lim + 1) * 4 * per;
			duty = (i == 0) ? 0 : (i == 1) ? 1023 : $unsigned($random(seed)) % ((lim + 1) * 4 + 2);
			wr(3'b100, (i % 2) ? 8'h00 : 8'h38, 8'h00, 8'h00, 2'(ps));
			meas(pd);
			chk(hi, 0, "pin off");
			wr(3'b111, {2'b00, 2'(duty), 4'hc}, 8'(duty >> 2), 8'(lim), 2'(ps));
			pend_q.push_back((duty >> 2) & 255);
			meas(3 * pd);
			model_match();
			meas(pd);
			chk(hi, exp_high(duty, lim, per), "high");
			chk(tmax, lim, "tmax");
			chk(shadow, model_sh, "shadow");
			$display("test %0d done lim %0d duty %0d ps %0d", i, lim, duty, per);
		end
		for (int k = 0; k < 5000 && timer !== 8'h01; k++) begin
			@(posedge i_mclk);
			#1;
		end
		chk(timer, 8'h01, "mid period");
		wr(3'b010, 8'h00, 8'(~(duty >> 2)), 8'h00, 2'(ps));
		pend_q.push_back((~(duty >> 2)) & 255);
		#1;
		chk(shadow, model_sh, "early");
		for (int k = 0; k < 5000 && timer !== 8'h00; k++) begin
			@(posedge i_mclk);
			#1;
		end
		chk(timer, 8'h00, "wrap");
		model_match();
		repeat (2) @(posedge i_mclk);
		#1;
		chk(shadow, model_sh, "late");
		$display("test deferred duty done");
		test_done();
	end
endmodule : testbench

// file: verilog/pwmg_core.sv
// Pulse-width generator core: period timer, duty double buffer, pin
// Operation
// - The pin carries a pulse-width signal of up to ten bits of duty resolution in PWM mode.
// - Clearing the whole control register forces the output latch low and, by leaving PWM mode, holds the timer at zero.
// - A period lasts (limit+1) times four clocks times the prescale.
// - When the timer equals the limit it clears on the next increment.
// - On that increment the pin goes high unless the duty is zero.
// - On that increment the written duty is copied into the shadow.
// - No postscaler affects the period.
// - Duty is the duty register above control bits five and four.
// - Duty writes are accepted anytime and take effect at the next period match.
// - The shadow cannot be written by software.
// - Shadow plus a two-bit latch double-buffer the duty.
// - The pin clears when the buffered duty equals the timer with two phase bits.
// - A duty longer than the period never clears the pin.
`timescale 1ns/10ps
module pwmg_core import pwmg_pkg::*; (
	input  wire logic      i_mclk,
	input  wire logic      i_rstn,
	input  wire pwmg_cfg_t i_cfg,
	output logic [7:0]     o_duty_value_shadow,
	output logic [7:0]     o_period_timer,
	output logic           o_pwm_output_pin
);
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] duty_w_q;
	logic [7:0] duty_w_d;
	logic [7:0] limit_q;
	logic [7:0] limit_d;
	logic [7:0] tmr_q;
	logic [7:0] tmr_d;
	logic [9:0] shadow_q;
	logic [9:0] shadow_d;
	logic       pin_q;
	logic       pin_d;
	logic       run;
	logic       tick;
	logic [1:0] phase;
	logic       match;
	logic [9:0] next_duty;
	logic [7:0] tmr_nx;

	// Duty compare against the timer value that lands at this edge
	function automatic logic duty_hit(input logic [9:0] d, input logic [7:0] t,
		input logic [1:0] p);
		return d == {t, p};
	endfunction : duty_hit

	assign run = pwmg_is_pwm(ctrl_q);

	pwmg_tick #(
		.PS_W(PWMG_PS_W)
	) u_tick (
		.i_mclk         (i_mclk),
		.i_rstn         (i_rstn),
		.i_run          (run),
		.i_prescale_sel (i_cfg.prescale_sel),
		.o_phase        (phase),
		.o_tick         (tick)
	);

	always_comb begin
		ctrl_d   = i_cfg.ctrl_we ? i_cfg.ctrl : ctrl_q;
		duty_w_d = i_cfg.duty_we ? i_cfg.duty : duty_w_q;
		limit_d  = i_cfg.limit_we ? i_cfg.limit : limit_q;
		next_duty = {duty_w_q, ctrl_q[PWMG_CTRL_LSB_HI:PWMG_CTRL_LSB_LO]};
		// Period from limit only, no postscaler
		match    = (tmr_q == limit_q);
		// Timer value after this edge; comparing with it absorbs the pin flop's delay
		if (!tick)
			tmr_nx = tmr_q;
		else if (match)
			tmr_nx = PWMG_TMR_RST;
		else
			tmr_nx = tmr_q + 8'h01;
		tmr_d    = tmr_q;
		shadow_d = shadow_q;
		pin_d    = pin_q;
		if (!run) begin
			tmr_d = PWMG_TMR_RST;
			pin_d = 1'b0;
		end else if (tick) begin
			if (match) begin
				tmr_d = PWMG_TMR_RST;
				shadow_d = next_duty;
				pin_d = (next_duty != 10'h000);
			end else begin
				tmr_d = tmr_q + 8'h01;
			end
		end
		// Clear on duty compare; never reached if too long
		if (run && !(tick && match) && pin_q && duty_hit(shadow_q, tmr_nx, phase))
			pin_d = 1'b0;
		if (i_cfg.ctrl_we && i_cfg.ctrl == PWMG_CTRL_RST)
			pin_d = 1'b0;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ctrl_q   <= PWMG_CTRL_RST;
			duty_w_q <= 8'h00;
			limit_q  <= PWMG_LIMIT_RST;
			tmr_q    <= PWMG_TMR_RST;
			shadow_q <= 10'h000;
			pin_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			duty_w_q <= duty_w_d;
			limit_q  <= limit_d;
			tmr_q    <= tmr_d;
			shadow_q <= shadow_d;
			pin_q    <= pin_d;
		end
	end

	// Shadow read only, out from a flop
	assign o_duty_value_shadow = shadow_q[9:2];
	assign o_period_timer      = tmr_q;
	assign o_pwm_output_pin    = pin_q;

	ctrl_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.ctrl_we && i_cfg.ctrl == 8'h00 |=> !o_pwm_output_pin)
		else $error("pin not low after control clear");
	timer_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && tick && match && !i_cfg.ctrl_we |=> o_period_timer == 8'h00)
		else $error("timer did not wrap at limit");
	pin_set_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && tick && match && next_duty != 0 && !i_cfg.ctrl_we |=> o_pwm_output_pin)
		else $error("pin not set at period start");
	zero_duty_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && tick && match && next_duty == 0 |=> !o_pwm_output_pin)
		else $error("pin set with zero duty");
	shadow_load_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && tick && match |=> shadow_q == $past(next_duty))
		else $error("shadow not loaded at match");
	shadow_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!(run && tick && match) |=> $stable(shadow_q))
		else $error("shadow changed mid period");
	duty_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && pin_q && !(tick && match) && duty_hit(shadow_q, tmr_nx, phase)
		|=> !o_pwm_output_pin)
		else $error("pin not cleared at duty compare");
	idle_low_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!run ##1 !run |-> !o_pwm_output_pin && o_period_timer == 8'h00)
		else $error("activity outside pwm mode");
	timer_step_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && !tick ##1 run |-> $stable(o_period_timer))
		else $error("timer moved without tick");
	pin_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && pin_q && !(tick && match) && !i_cfg.ctrl_we
		&& !duty_hit(shadow_q, tmr_nx, phase) |=> o_pwm_output_pin)
		else $error("pin cleared without duty compare");
	rise_at_match_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!(run && tick && match) |=> !$rose(o_pwm_output_pin))
		else $error("pin rose away from period start");
	timer_inc_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && tick && !match |=> o_period_timer == $past(tmr_q) + 8'h01)
		else $error("timer did not step by one");
	duty_write_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.duty_we |=> duty_w_q == $past(i_cfg.duty))
		else $error("duty write lost");
	tick_off_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!run |=> !tick)
		else $error("tick outside pwm mode");

	// Period length watch: counts clocks between period starts while the
	// limit and prescale stay put, so a changed setting cannot trip it
	logic [15:0] per_cnt_q;
	logic [15:0] per_cnt_d;
	logic [15:0] per_exp;
	logic        per_ok_q;
	logic        per_ok_d;
	logic [1:0]  ps_q;

	function automatic logic [2:0] ps_shift(input logic [1:0] sel);
		case (sel)
			2'h0:    return 3'h0;
			2'h1:    return 3'h2;
			default: return 3'h4;
		endcase
	endfunction : ps_shift

	always_comb begin
		per_exp  = (({8'h00, limit_q} + 16'h0001) * 16'(PWMG_QCLK_DIV)) << ps_shift(ps_q);
		per_ok_d = !run || (per_ok_q && !i_cfg.limit_we && i_cfg.prescale_sel == ps_q);
		if (!run)
			per_cnt_d = 16'h0000;
		else if (tick && match)
			per_cnt_d = 16'h0001;
		else
			per_cnt_d = per_cnt_q + 16'h0001;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			per_cnt_q <= 16'h0000;
			per_ok_q  <= 1'b0;
			ps_q      <= 2'h0;
		end else begin
			per_cnt_q <= per_cnt_d;
			per_ok_q  <= per_ok_d;
			ps_q      <= i_cfg.prescale_sel;
		end
	end

	period_len_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		run && per_ok_q && tick && match |-> per_cnt_q == per_exp)
		else $error("period length off");
endmodule : pwmg_core

// file: verilog/pwmg_tick.sv
// Prescaled increment tick and two-bit phase for the period timer
`timescale 1ns/10ps
module pwmg_tick import pwmg_pkg::*; #(
	parameter int PS_W = PWMG_PS_W
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic       i_run,
	input  wire logic [1:0] i_prescale_sel,
	output logic [1:0]      o_phase,
	output logic            o_tick
);
	logic [PS_W+1:0] cnt_q;
	logic [PS_W+1:0] cnt_d;
	logic [PS_W+1:0] top;
	logic            tick_d;
	logic            tick_q;
	logic [1:0]      phase_d;
	logic [1:0]      phase_q;

	// Four clocks times 1, 4 or 16
	always_comb begin
		case (i_prescale_sel)
			2'h0:    top = (PS_W+2)'(PWMG_QCLK_DIV - 1);
			2'h1:    top = (PS_W+2)'(PWMG_QCLK_DIV * 4 - 1);
			default: top = (PS_W+2)'(PWMG_QCLK_DIV * 16 - 1);
		endcase
		tick_d  = i_run && (cnt_q >= top);
		cnt_d   = (!i_run || tick_d) ? '0 : cnt_q + 1'b1;
		case (i_prescale_sel)
			2'h0:    phase_d = cnt_d[1:0];
			2'h1:    phase_d = cnt_d[3:2];
			default: phase_d = cnt_d[5:4];
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			cnt_q   <= '0;
			tick_q  <= 1'b0;
			phase_q <= 2'h0;
		end else begin
			cnt_q   <= cnt_d;
			tick_q  <= tick_d;
			phase_q <= phase_d;
		end
	end

	assign o_tick  = tick_q;
	assign o_phase = phase_q;

	tick_phase_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		o_tick |-> o_phase == 2'h0)
		else $error("tick off phase zero");
endmodule : pwmg_tick
